//--- pkg/shift_pkg.sv
package shift_pkg;

  localparam int STAGES = 16;
  localparam int FIFO_DEPTH = 32;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_FIFO   = 8'h08;
  localparam logic [7:0] OFS_LEVEL  = 8'h0c;

  // control fields
  localparam int CTRL_CAPTURE_BIT = 0;
  localparam int CTRL_FLUSH_BIT   = 1;
  localparam int CTRL_CLR_OVF_BIT = 2;
  localparam logic CTRL_CAPTURE_RESET = 1'h0;

  // status fields, stage contents sit in the low bits
  localparam int STATUS_EMPTY_BIT  = 16;
  localparam int STATUS_FULL_BIT   = 17;
  localparam int STATUS_KNOWN_BIT  = 18;
  localparam int STATUS_OVF_BIT    = 19;
  localparam int STATUS_SELECT_BIT = 20;
  localparam int STATUS_MODE_BIT   = 21;

  // fifo word read: bit 31 flags a valid entry
  localparam int FIFO_VALID_BIT = 31;

  // shifts after which the whole register holds defined data
  localparam logic [4:0] SHIFTS_TO_KNOWN = 5'h10;
  localparam logic [4:0] SHIFT_COUNT_RESET = 5'h00;

  typedef struct packed {
    logic                falling_edge_clock;
    logic                select_n;
    logic                mode;
    logic                serial_in;
    logic [STAGES-1:0]   parallel_inputs;
  } pins_t;

  // select idles high (hold), clock idles low so a high pin at release is no edge
  localparam pins_t PINS_RESET = '{
    falling_edge_clock: 1'h0,
    select_n:           1'h1,
    mode:               1'h0,
    serial_in:          1'h0,
    parallel_inputs:    16'h0000
  };

  typedef enum {OP_HOLD, OP_SHIFT, OP_LOAD} op_t;

endpackage : shift_pkg

//--- sim/pin_driver.sv
`timescale 1ns/1ps
`default_nettype none
module pin_driver (
  // clock
  input wire logic             clk,
  // device pins
  output var shift_pkg::pins_t pins
);
  initial pins = shift_pkg::PINS_RESET;
  // controls change only while the pin clock is low, so select never rises under a high clock
  task automatic pulse(input logic sel_n, input logic mode, input logic si,
                       input logic [15:0] par);
    @(posedge clk);
    pins <= '{1'b0, sel_n, mode, si, par};
    repeat (4) @(posedge clk);
    pins.falling_edge_clock <= 1'b1;
    repeat (4) @(posedge clk);
    pins.falling_edge_clock <= 1'b0;
    repeat (8) @(posedge clk);
  endtask : pulse
endmodule : pin_driver
`default_nettype wire

//--- sim/shift_register_properties.sv
`timescale 1ns/1ps
`default_nettype none
module shift_register_properties (
  // clock and reset
  input wire logic             clk,
  input wire logic             rst_n,
  // apb
  input wire logic             psel,
  input wire logic             penable,
  input wire logic             pwrite,
  input wire logic [7:0]       paddr,
  input wire logic [31:0]      pwdata,
  input wire logic [31:0]      prdata,
  input wire logic             pready,
  input wire logic             pslverr,
  // pins
  input wire shift_pkg::pins_t pins,
  input wire logic             serial_out,
  input wire logic             contents_known,
  input wire logic             capture_ready
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] since_fall;
  // pins pass a filter, so effects trail a raw fall by a few cycles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) since_fall <= 5'h1f;
    else if ($fell(pins.falling_edge_clock)) since_fall <= 5'h01;
    else if (since_fall != 5'h1f) since_fall <= since_fall + 5'h01;
  end
  ////////////////////////////////////////////////////////////
  hold_freeze_a: assert property ((contents_known && pins.select_n) [*8] |=> $stable(serial_out))
    else $error("serial output moved while held");
  load_out_a: assert property (($fell(pins.falling_edge_clock) && !pins.select_n && pins.mode
    ##1 $stable(pins) [*7]) |-> serial_out == pins.parallel_inputs[15])
    else $error("serial output is not top parallel bit after load");
  out_timing_a: assert property (contents_known && $changed(serial_out) |-> since_fall inside {[3:8]})
    else $error("serial output changed without a clock fall");
  known_rise_a: assert property ($rose(contents_known) |-> since_fall inside {[3:8]})
    else $error("known flag rose without a clock fall");
  known_keep_a: assert property (contents_known |=> contents_known)
    else $error("known flag dropped");
  apb_wait_a: assert property ($rose(penable) && psel |=> pready)
    else $error("apb answer not after one wait state");
  ready_phase_a: assert property (pready |-> psel && penable)
    else $error("pready outside access phase");
  err_unmapped_a: assert property (pready && paddr > 8'h0c |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  err_mapped_a: assert property (pready && paddr inside {8'h00, 8'h04, 8'h08, 8'h0c} |-> !pslverr)
    else $error("mapped access refused");
  write_zero_a: assert property (pready && pwrite |-> prdata == 32'h0)
    else $error("read data not zero on write");
  load_c: cover property ($fell(pins.falling_edge_clock) && !pins.select_n && pins.mode);
  hold_c: cover property ($fell(pins.falling_edge_clock) && pins.select_n);
  unmapped_c: cover property (pready && pslverr);
endmodule : shift_register_properties
bind shift_register_top shift_register_properties chk (.clk, .rst_n, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .pins, .serial_out, .contents_known,
  .capture_ready);
`default_nettype wire

//--- sim/tb_parallel_serial_shift_register.sv
`timescale 1ns/1ps
`default_nettype none
module tb_parallel_serial_shift_register;
  localparam int DEPTH = 4;
  logic             clk;
  logic             rst_n;
  logic             psel;
  logic             penable;
  logic             pwrite;
  logic [7:0]       paddr;
  logic [31:0]      pwdata;
  logic [31:0]      prdata;
  logic             pready;
  logic             pslverr;
  shift_pkg::pins_t pins;
  logic             serial_out;
  logic             contents_known;
  logic             capture_ready;
  int               err_count;
  int               checks;
  logic [15:0]      exp_stages;
  logic             capture;
  logic [15:0]      exp_q[$];

  pin_driver drv (.clk(clk), .pins(pins));
  shift_register_top #(.FIFO_DEPTH(DEPTH)) dut (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pins(pins), .serial_out(serial_out),
    .contents_known(contents_known), .capture_ready(capture_ready));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] d, output logic err);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    // judge pready at the rising edge, the same edge at which the slave completes
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(1'b0, a, 32'h0, d, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] d;
    logic        e;
    apb(1'b1, a, wd, d, e);
  endtask : wr

  task automatic op(input logic sel_n, input logic mode, input logic si, input logic [15:0] par);
    drv.pulse(sel_n, mode, si, par);
    if (!sel_n) begin
      exp_stages = mode ? par : {exp_stages[14:0], si};
      if (capture && exp_q.size() < DEPTH) exp_q.push_back(exp_stages);
    end
  endtask : op

  task automatic status_check;
    logic [31:0] d;
    rd(shift_pkg::OFS_STATUS, d);
    check("stages", {16'h0, d[15:0]}, {16'h0, exp_stages});
    check("serial_out", {31'h0, serial_out}, {31'h0, exp_stages[15]});
  endtask : status_check

  task automatic t_apb;
    logic [31:0] d;
    logic        e;
    rd(shift_pkg::OFS_CTRL, d);
    check("ctrl reset", d, 32'h0);
    apb(1'b0, 8'h10, 32'h0, d, e);
    check("unmapped", {e, d[30:0]}, 32'h80000000);
    wr(shift_pkg::OFS_CTRL, 32'h1);
    capture = 1'b1;
    rd(shift_pkg::OFS_CTRL, d);
    check("ctrl capture", {31'h0, d[0]}, 32'h1);
    $display("test apb done");
  endtask : t_apb

  task automatic t_load;
    check("known early", {31'h0, contents_known}, 32'h0);
    for (int i = 0; i < 2; i++) begin
      op(1'b0, 1'b1, 1'b0, i ? 16'h7ffe : 16'h8001);
      status_check();
    end
    check("known", {31'h0, contents_known}, 32'h1);
    $display("test load done");
  endtask : t_load

  task automatic t_shift;
    logic [3:0] bits;
    bits = 4'hb;
    for (int i = 3; i >= 0; i--) begin
      op(1'b0, 1'b0, bits[i], 16'h0000);
      status_check();
    end
    $display("test shift done");
  endtask : t_shift

  task automatic t_hold;
    for (int m = 0; m < 2; m++) begin
      op(1'b1, m[0], 1'b1, 16'hffff);
      status_check();
    end
    $display("test hold done");
  endtask : t_hold

  task automatic t_fifo;
    logic [31:0] d;
    rd(shift_pkg::OFS_LEVEL, d);
    check("level", d, DEPTH);
    check("ready when full", {31'h0, capture_ready}, 32'h0);
    rd(shift_pkg::OFS_STATUS, d);
    check("full ovf", {26'h0, d[21:16]}, 32'h3e);
    while (exp_q.size() > 0) begin
      rd(shift_pkg::OFS_FIFO, d);
      check("fifo word", d, {16'h8000, exp_q.pop_front()});
    end
    rd(shift_pkg::OFS_FIFO, d);
    check("empty valid", {31'h0, d[31]}, 32'h0);
    wr(shift_pkg::OFS_CTRL, 32'h5);
    rd(shift_pkg::OFS_STATUS, d);
    check("empty ovf", {30'h0, d[19], d[16]}, 32'h1);
    op(1'b0, 1'b0, 1'b0, 16'h0000);
    wr(shift_pkg::OFS_CTRL, 32'h3);
    exp_q.delete();
    rd(shift_pkg::OFS_LEVEL, d);
    check("flushed", d, 32'h0);
    check("ready after flush", {31'h0, capture_ready}, 32'h1);
    $display("test fifo done");
  endtask : t_fifo

  // stages carry no reset, so a mid-run reset keeps them but forgets that they are known
  task automatic t_reset;
    logic [31:0] d;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    capture = 1'b0;
    rd(shift_pkg::OFS_STATUS, d);
    check("kept stages", {16'h0, d[15:0]}, {16'h0, exp_stages});
    check("known after reset", {31'h0, d[18]}, 32'h0);
    for (int i = 0; i < 16; i++) begin
      check("known too soon", {31'h0, contents_known}, 32'h0);
      op(1'b0, 1'b0, i[0], 16'h0000);
      check("serial_out", {31'h0, serial_out}, {31'h0, exp_stages[15]});
    end
    check("known by shifts", {31'h0, contents_known}, 32'h1);
    status_check();
    $display("test reset done");
  endtask : t_reset

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    $display("watchdog expired");
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    capture = 1'b0;
    err_count = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_apb();
    t_load();
    t_shift();
    t_hold();
    t_fifo();
    t_reset();
    summarize();
  end
endmodule : tb_parallel_serial_shift_register
`default_nettype wire

//--- src/shift_register_top.sv
// Design decisions made here: the address map and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module shift_register_top #(
  parameter int FIFO_DEPTH = shift_pkg::FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // apb slave
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [7:0]                    paddr,
  input  wire logic [31:0]                   pwdata,
  output logic [31:0]                        prdata,
  output logic                               pready,
  output logic                               pslverr,
  // device pins
  input  wire shift_pkg::pins_t              pins,
  output logic                               serial_out,
  // status towards surrounding logic
  output logic                               contents_known,
  output logic                               capture_ready
);

  localparam int PW = $bits(shift_pkg::pins_t);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [PW-1:0]     sync1;
  logic [PW-1:0]     sync2;
  logic [PW-1:0]     sync3;
  logic [PW-1:0]     filt_bits;
  logic [PW-1:0]     next_filt_bits;
  shift_pkg::pins_t  filt;

  assign filt = shift_pkg::pins_t'(filt_bits);

  // a pin counts as changed only once the second and third stages agree,
  // which rejects a single-sample glitch at the cost of one more cycle
  genvar gi;
  generate
    for (gi = 0; gi < PW; gi++) begin : g_sync
      localparam logic RST_BIT = shift_pkg::PINS_RESET[gi];

      always_comb begin
        next_filt_bits[gi] = filt_bits[gi];
        if (sync2[gi] == sync3[gi]) begin
          next_filt_bits[gi] = sync2[gi];
        end
      end

      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          sync1[gi]     <= RST_BIT;
          sync2[gi]     <= RST_BIT;
          sync3[gi]     <= RST_BIT;
          filt_bits[gi] <= RST_BIT;
        end else begin
          sync1[gi]     <= pins[gi];
          sync2[gi]     <= sync1[gi];
          sync3[gi]     <= sync2[gi];
          filt_bits[gi] <= next_filt_bits[gi];
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // falling edge of the pin clock and operation select

  logic              clk_prev;
  logic              next_clk_prev;
  logic              pin_fall;
  shift_pkg::op_t    op;

  assign next_clk_prev = filt.falling_edge_clock;
  assign pin_fall      = clk_prev && !filt.falling_edge_clock;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_prev <= 1'h0;
    end else begin
      clk_prev <= next_clk_prev;
    end
  end

  // select is sampled through the same delay as the clock pin, so a select
  // rising while the clock pin is held low cannot fake an edge
  always_comb begin
    op = shift_pkg::OP_HOLD;
    if (!filt.select_n) begin
      if (filt.mode) begin
        op = shift_pkg::OP_LOAD;
      end else begin
        op = shift_pkg::OP_SHIFT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // storage stages

  logic [shift_pkg::STAGES-1:0] stages;
  logic [shift_pkg::STAGES-1:0] next_stages;

  always_comb begin
    next_stages = stages;
    if (pin_fall) begin
      case (op)
        shift_pkg::OP_LOAD: begin
          next_stages = filt.parallel_inputs;
        end
        shift_pkg::OP_SHIFT: begin
          next_stages = {stages[shift_pkg::STAGES-2:0], filt.serial_in};
        end
        default: begin
          next_stages = stages;
        end
      endcase
    end
  end

  // deliberately left without reset: a reset would claim knowledge the
  // device does not have after power-up
  always_ff @(posedge clk) begin
    stages <= next_stages;
  end

  assign serial_out = stages[shift_pkg::STAGES-1];

  //////////////////////////////////////////////////////////////////////////////
  // tracking when the contents become defined

  logic [4:0] shift_count;
  logic [4:0] next_shift_count;
  logic       known;
  logic       next_known;

  always_comb begin
    next_shift_count = shift_count;
    next_known       = known;
    if (pin_fall) begin
      case (op)
        shift_pkg::OP_LOAD: begin
          next_known = 1'h1;
        end
        shift_pkg::OP_SHIFT: begin
          if (!known) begin
            next_shift_count = shift_count + 5'h01;
            if (next_shift_count == shift_pkg::SHIFTS_TO_KNOWN) begin
              next_known = 1'h1;
            end
          end
        end
        default: begin
          next_known = known;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_count <= shift_pkg::SHIFT_COUNT_RESET;
      known       <= 1'h0;
    end else begin
      shift_count <= next_shift_count;
      known       <= next_known;
    end
  end

  assign contents_known = known;

  //////////////////////////////////////////////////////////////////////////////
  // capture of each new register word into the fifo

  logic                         capture_en;
  logic                         next_capture_en;
  logic                         cap_valid;
  logic                         cap_ready;
  logic                         overflow;
  logic                         next_overflow;
  logic                         fifo_flush;
  logic                         fifo_out_valid;
  logic                         fifo_pop;
  logic [shift_pkg::STAGES-1:0] fifo_out_data;
  logic [LW-1:0]                fifo_level;

  // the pin clock cannot be stalled, so a word offered while full is lost
  // and only flagged; capture_ready lets the outside logic pause instead
  assign cap_valid     = pin_fall && (op != shift_pkg::OP_HOLD) && capture_en;
  assign capture_ready = cap_ready;

  word_fifo #(
    .WIDTH (shift_pkg::STAGES),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .flush     (fifo_flush),
    .level     (fifo_level),
    .in_valid  (cap_valid),
    .in_ready  (cap_ready),
    .in_data   (next_stages),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_out_data)
  );

  //////////////////////////////////////////////////////////////////////////////
  // apb slave: one wait state so read data comes from a flip-flop

  logic        access;
  logic        ack;
  logic        next_ack;
  logic        complete;
  logic        wr_done;
  logic [31:0] rd_value;
  logic        rd_error;
  logic [31:0] next_prdata;
  logic        next_pslverr;

  assign access   = psel && penable;
  assign next_ack = access && !ack;
  assign complete = access && ack;
  assign wr_done  = complete && pwrite;
  assign pready   = ack;

  always_comb begin
    rd_value = 32'h0000_0000;
    rd_error = 1'h0;
    if (paddr == shift_pkg::OFS_CTRL) begin
      rd_value[shift_pkg::CTRL_CAPTURE_BIT] = capture_en;
    end else if (paddr == shift_pkg::OFS_STATUS) begin
      rd_value[shift_pkg::STAGES-1:0]         = stages;
      rd_value[shift_pkg::STATUS_EMPTY_BIT]  = !fifo_out_valid;
      rd_value[shift_pkg::STATUS_FULL_BIT]   = !cap_ready;
      rd_value[shift_pkg::STATUS_KNOWN_BIT]  = known;
      rd_value[shift_pkg::STATUS_OVF_BIT]    = overflow;
      rd_value[shift_pkg::STATUS_SELECT_BIT] = filt.select_n;
      rd_value[shift_pkg::STATUS_MODE_BIT]   = filt.mode;
    end else if (paddr == shift_pkg::OFS_FIFO) begin
      rd_value[shift_pkg::STAGES-1:0]        = fifo_out_data;
      rd_value[shift_pkg::FIFO_VALID_BIT]    = fifo_out_valid;
    end else if (paddr == shift_pkg::OFS_LEVEL) begin
      rd_value[LW-1:0]                       = fifo_level;
    end else begin
      rd_error = 1'h1;
    end
  end

  always_comb begin
    next_prdata  = prdata;
    next_pslverr = pslverr;
    if (next_ack) begin
      next_prdata  = pwrite ? 32'h0000_0000 : rd_value;
      next_pslverr = rd_error;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack     <= 1'h0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'h0;
    end else begin
      ack     <= next_ack;
      prdata  <= next_prdata;
      pslverr <= next_pslverr;
    end
  end

  // a fifo read pops only at the completing edge, and only a real entry
  assign fifo_pop = complete && !pwrite && (paddr == shift_pkg::OFS_FIFO) && fifo_out_valid;

  //////////////////////////////////////////////////////////////////////////////
  // control register and overflow flag

  logic ctrl_wr;

  assign ctrl_wr    = wr_done && (paddr == shift_pkg::OFS_CTRL);
  assign fifo_flush = ctrl_wr && pwdata[shift_pkg::CTRL_FLUSH_BIT];

  always_comb begin
    next_capture_en = capture_en;
    next_overflow   = overflow;
    if (ctrl_wr) begin
      next_capture_en = pwdata[shift_pkg::CTRL_CAPTURE_BIT];
      if (pwdata[shift_pkg::CTRL_CLR_OVF_BIT]) begin
        next_overflow = 1'h0;
      end
    end
    // a lost word in the clearing cycle still sets the flag
    if (cap_valid && !cap_ready) begin
      next_overflow = 1'h1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capture_en <= shift_pkg::CTRL_CAPTURE_RESET;
      overflow   <= 1'h0;
    end else begin
      capture_en <= next_capture_en;
      overflow   <= next_overflow;
    end
  end

endmodule : shift_register_top
`default_nettype wire

//--- src/word_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  // control
  input  wire logic                     flush,
  output logic [$clog2(DEPTH):0]        level,
  // filling side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [WIDTH-1:0]         in_data,
  // draining side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [WIDTH-1:0]              out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  logic [AW:0]      next_wr_ptr;
  logic [AW:0]      next_rd_ptr;
  logic             push;
  logic             pop;

  assign level     = wr_ptr - rd_ptr;
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (level != '0);
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_rd_ptr = wr_ptr;
    end else begin
      if (push) begin
        next_wr_ptr = wr_ptr + 1'b1;
      end
      if (pop) begin
        next_rd_ptr = rd_ptr + 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  // storage needs no reset, the pointers say what is valid
  always_ff @(posedge clk) begin
    if (push && !flush) begin
      mem[wr_ptr[AW-1:0]] <= in_data;
    end
  end

endmodule : word_fifo
`default_nettype wire
